// ---- design/defs_defines.svh ----
`ifndef DEFS_DEFINES_SVH
`define DEFS_DEFINES_SVH
// ************************************************
// Clock and delay timing
// ************************************************
`define DEFS_CLK_KHZ         20000
`define DEFS_STEP_MS         20
`define DEFS_STEP_CYCLES     (`DEFS_STEP_MS * `DEFS_CLK_KHZ)
`define DEFS_DELAY_MAX_S     300
`define DEFS_DELAY_MAX_STEPS (14'(`DEFS_DELAY_MAX_S * 1000 / `DEFS_STEP_MS))
// ************************************************
// Fundamental filter
// ************************************************
`define DEFS_NSAMP           16
`define DEFS_LAST_SAMPLE     4'hF
`define DEFS_SIN_OFFSET      4'hC
`define DEFS_DFT_SHIFT       17
`define DEFS_ROT_SHIFT       14
`define DEFS_COS_SQ_SHIFT    28
`define DEFS_HARM3_ATTEN_DB  60
// ************************************************
// Sample scaling and saturation
// ************************************************
`define DEFS_I0_RATED        18'sh00800
`define DEFS_PH_RATED        18'sh00100
`define DEFS_I0_SAT_MULT     10
`define DEFS_PH_SAT_MULT     50
`define DEFS_I0_SAT          (18'(`DEFS_I0_SAT_MULT) * `DEFS_I0_RATED)
`define DEFS_PH_SAT          (18'(`DEFS_PH_SAT_MULT) * `DEFS_PH_RATED)
`define DEFS_INV_SQRT3       17'h093CD
`define DEFS_INV_THREE       18'sh05555
`define DEFS_PCT_FULL        7'h64
`endif

// ---- design/defs_pkg.sv ----
package defs_pkg;
	// ************************************************
	// Modes, sources and carriers
	// ************************************************
	typedef enum logic [2:0] {
		DEFS_NONDIRECTIONAL,
		DEFS_RESISTIVE,
		DEFS_CAPACITIVE,
		DEFS_SWITCHED_RESISTIVE_CAPACITIVE_MODE,
		DEFS_SECTOR
	} defs_mode_t;

	typedef enum logic [1:0] {
		DEFS_SRC_RESIDUAL_ONE,
		DEFS_SRC_RESIDUAL_TWO,
		DEFS_SRC_SUMMED
	} defs_src_t;

	// Per-stage settings; angles given as Q14 cosine and sine
	typedef struct packed {
		defs_mode_t         mode;
		defs_src_t          source;
		logic               dependent;
		logic [15:0]        start_level;
		logic [6:0]         start_volt_pct;
		logic signed [15:0] base_cos;
		logic signed [15:0] base_sin;
		logic [15:0]        half_cos;
		logic [13:0]        op_delay;
		logic [13:0]        int_time;
	} defs_cfg_t;

	typedef struct packed {
		logic signed [17:0] re;
		logic signed [17:0] im;
	} defs_phasor_t;

	typedef struct packed {
		logic start_on;
		logic start_off;
		logic trip_on;
		logic trip_off;
	} defs_event_t;
endpackage : defs_pkg

// ---- design/defs_stage.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "defs_defines.svh"
module defs_stage #(
	parameter int unsigned STEP_CYCLES = `DEFS_STEP_CYCLES // Clocks per delay step
) (
	input  wire logic                        core_clk,                        // 20 MHz clock
	input  wire logic                        rst_n,                           // Async reset, active low
	input  wire logic                        sample_valid,                    // New sample set, 16 per cycle
	input  wire logic signed [17:0]          residual_input_one,              // Residual current one
	input  wire logic signed [17:0]          residual_input_two,              // Residual current two
	input  wire logic signed [17:0]          phase_a_current,                 // Phase A current
	input  wire logic signed [17:0]          phase_b_current,                 // Phase B current
	input  wire logic signed [17:0]          phase_c_current,                 // Phase C current
	input  wire logic signed [17:0]          neutral_displacement_voltage,    // Measured neutral voltage
	input  wire logic signed [17:0]          line_a_voltage,                  // Phase A voltage
	input  wire logic signed [17:0]          line_b_voltage,                  // Phase B voltage
	input  wire logic signed [17:0]          line_c_voltage,                  // Phase C voltage
	input  wire logic                        mode_select_input,               // High selects capacitive
	input  wire logic                        derived_voltage_mode,            // No neutral voltage input
	input  wire logic [15:0]                 vt_nominal,                      // Phase VT rating, sample units
	input  wire logic [15:0]                 neutral_voltage_transformer_sec, // Neutral VT secondary
	input  wire defs_pkg::defs_cfg_t [1:0]   stage_cfg,                       // Stage settings
	input  wire logic [1:0]                  block_in,                        // Stage block inputs
	input  wire logic [1:0]                  event_enable,                    // Event recording enables
	output logic [1:0]                       start_out,                       // Stage start, registered
	output logic [1:0]                       trip_out,                        // Stage trip, registered
	output defs_pkg::defs_event_t [1:0]      stage_event                      // Event pulses, registered
);
	import defs_pkg::*;

	// ************************************************
	// Helper functions
	// ************************************************
	// Symmetric clamp for input saturation
	function automatic logic signed [17:0] defs_sat(input logic signed [17:0] x, input logic signed [17:0] lim);
		if (x > lim)
			return lim;
		else if (x < -lim)
			return -lim;
		return x;
	endfunction : defs_sat

	// Q14 cosine of 2*pi*k/16, folded onto one quarter
	function automatic logic signed [15:0] defs_cos16(input logic [3:0] k);
		logic [3:0]         m;
		logic [3:0]         q;
		logic signed [15:0] mag;
		m = k[3] ? (4'h0 - k) : k;
		q = (m > 4'h4) ? (4'h8 - m) : m;
		unique case (q)
			4'h0: mag = 16'sh4000;
			4'h1: mag = 16'sh3B21;
			4'h2: mag = 16'sh2D41;
			4'h3: mag = 16'sh187E;
			default: mag = 16'sh0000;
		endcase
		return (m > 4'h4) ? -mag : mag;
	endfunction : defs_cos16

	// Residual source selection
	function automatic logic signed [17:0] defs_pick(input defs_src_t src, input logic signed [17:0] one,
		input logic signed [17:0] two, input logic signed [17:0] sum);
		unique case (src)
			DEFS_SRC_RESIDUAL_ONE: return one;
			DEFS_SRC_RESIDUAL_TWO: return two;
			DEFS_SRC_SUMMED:       return sum;
			default:               return one;
		endcase
	endfunction : defs_pick

	// Squared phasor magnitude
	function automatic logic [36:0] defs_mag2(input defs_phasor_t ph);
		return 37'(ph.re * ph.re) + 37'(ph.im * ph.im);
	endfunction : defs_mag2

	// Ratio class of current over start level: 2x, 4x, 8x
	function automatic logic [1:0] defs_rate(input defs_phasor_t ph, input logic [15:0] lvl);
		logic [39:0] i2;
		logic [39:0] l2;
		i2 = 40'(defs_mag2(ph));
		l2 = 40'(lvl) * 40'(lvl);
		if (i2 >= (l2 << 6))
			return 2'h3;
		else if (i2 >= (l2 << 4))
			return 2'h2;
		else if (i2 >= (l2 << 2))
			return 2'h1;
		return 2'h0;
	endfunction : defs_rate

	// Start criteria; products against |U| avoid any division or root
	function automatic logic defs_criteria(input defs_phasor_t ip, input defs_phasor_t up,
		input defs_mode_t md, input defs_cfg_t c, input logic [31:0] u_thr_sq);
		logic signed [37:0]  p;
		logic signed [37:0]  q;
		logic signed [55:0]  pr_w;
		logic signed [55:0]  qr_w;
		logic signed [39:0]  pr;
		logic signed [39:0]  qr;
		logic        [36:0]  u2;
		logic        [31:0]  lvl2;
		logic        [79:0]  lvl2u2;
		logic        [79:0]  pr2;
		logic        [79:0]  qr2;
		logic        [103:0] sect_r;
		logic                volt_ok;
		logic                mag_ok;
		logic                hit;
		p       = 38'(ip.re * up.re) + 38'(ip.im * up.im);
		q       = 38'(ip.im * up.re) - 38'(ip.re * up.im);
		pr_w    = 56'(p * c.base_cos) + 56'(q * c.base_sin);
		qr_w    = 56'(q * c.base_cos) - 56'(p * c.base_sin);
		pr      = 40'(pr_w >>> `DEFS_ROT_SHIFT);
		qr      = 40'(qr_w >>> `DEFS_ROT_SHIFT);
		u2      = defs_mag2(up);
		lvl2    = 32'(c.start_level) * 32'(c.start_level);
		lvl2u2  = 80'(lvl2) * 80'(u2);
		pr2     = 80'(pr * pr);
		qr2     = 80'(qr * qr);
		sect_r  = 104'(c.half_cos) * 104'(c.half_cos) * 104'(pr2 + qr2);
		volt_ok = u2 >= 37'(u_thr_sq);
		mag_ok  = defs_mag2(ip) >= 37'(lvl2);
		unique case (md)
			DEFS_NONDIRECTIONAL: hit = mag_ok;
			DEFS_RESISTIVE:      hit = volt_ok && (pr > 40'sh0) && (pr2 >= lvl2u2);
			DEFS_CAPACITIVE:     hit = volt_ok && (qr > 40'sh0) && (qr2 >= lvl2u2);
			DEFS_SECTOR:         hit = volt_ok && mag_ok && (pr > 40'sh0)
			                           && ((104'(pr2) << `DEFS_COS_SQ_SHIFT) >= sect_r);
			default:             hit = 1'b0;
		endcase
		return hit;
	endfunction : defs_criteria

	// ************************************************
	// Input conditioning
	// ************************************************
	// Clamp like the analogue front end so curves see the same limits
	wire signed [17:0] res_one_c = defs_sat(residual_input_one, `DEFS_I0_SAT);
	wire signed [17:0] res_two_c = defs_sat(residual_input_two, `DEFS_I0_SAT);
	wire signed [19:0] phase_sum = 20'(defs_sat(phase_a_current, `DEFS_PH_SAT))
	                             + 20'(defs_sat(phase_b_current, `DEFS_PH_SAT))
	                             + 20'(defs_sat(phase_c_current, `DEFS_PH_SAT));
	// Three saturated phases stay inside 18 bits
	wire signed [17:0] summed_phase_residual = 18'(phase_sum);

	// Derived neutral voltage is the mean of the three phases
	wire signed [19:0] line_sum   = 20'(line_a_voltage) + 20'(line_b_voltage) + 20'(line_c_voltage);
	wire signed [37:0] line_third = line_sum * `DEFS_INV_THREE;

	// Channels 0 and 1 feed the stages, channel 2 is the polarising voltage
	logic signed [17:0] chan_x [3];
	assign chan_x[0] = defs_pick(stage_cfg[0].source, res_one_c, res_two_c, summed_phase_residual);
	assign chan_x[1] = defs_pick(stage_cfg[1].source, res_one_c, res_two_c, summed_phase_residual);
	assign chan_x[2] = derived_voltage_mode ? 18'(line_third >>> 16) : neutral_displacement_voltage;

	// ************************************************
	// Fundamental extraction
	// ************************************************
	// Full-cycle correlation nulls every harmonic up to the seventh
	logic        [3:0]  samp_idx_q;
	logic signed [39:0] acc_re_q [3];
	logic signed [39:0] acc_im_q [3];
	logic signed [39:0] re_next  [3];
	logic signed [39:0] im_next  [3];
	defs_phasor_t       phasor_q [3];
	logic               eval_q;
	wire  signed [15:0] coef_re  = defs_cos16(samp_idx_q);
	wire  signed [15:0] coef_im  = -defs_cos16(samp_idx_q + `DEFS_SIN_OFFSET);
	wire                last_smp = samp_idx_q == `DEFS_LAST_SAMPLE;

	// Running sums including the present sample
	always_comb begin
		for (int c = 0; c < 3; c++) begin
			re_next[c] = acc_re_q[c] + 40'(chan_x[c] * coef_re);
			im_next[c] = acc_im_q[c] + 40'(chan_x[c] * coef_im);
		end
	end

	// Phasor latched once per cycle, accumulators restart
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			samp_idx_q <= 4'h0;
			eval_q     <= 1'b0;
			for (int c = 0; c < 3; c++) begin
				acc_re_q[c] <= 40'sh0;
				acc_im_q[c] <= 40'sh0;
				phasor_q[c] <= '0;
			end
		end else begin
			eval_q <= sample_valid && last_smp;
			if (sample_valid) begin
				samp_idx_q <= samp_idx_q + 4'h1;
				for (int c = 0; c < 3; c++) begin
					acc_re_q[c] <= last_smp ? 40'sh0 : re_next[c];
					acc_im_q[c] <= last_smp ? 40'sh0 : im_next[c];
					if (last_smp)
						phasor_q[c] <= '{re: 18'(re_next[c] >>> `DEFS_DFT_SHIFT),
						                 im: 18'(im_next[c] >>> `DEFS_DFT_SHIFT)};
				end
			end
		end
	end

	// ************************************************
	// Start evaluation
	// ************************************************
	// Voltage base follows the measurement mode
	wire [32:0] vt_scaled = vt_nominal * `DEFS_INV_SQRT3;
	wire [15:0] u_base    = derived_voltage_mode ? vt_scaled[31:16] : neutral_voltage_transformer_sec;

	defs_mode_t  eff_mode [2];
	logic [31:0] u_thr_sq [2];
	logic [1:0]  crit_w;
	logic [1:0]  rate_w   [2];
	logic [22:0] u_pct    [2];
	logic [15:0] u_thr    [2];

	// Switched mode resolved here so the criteria see a plain mode
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			if (stage_cfg[s].mode == DEFS_SWITCHED_RESISTIVE_CAPACITIVE_MODE)
				eff_mode[s] = mode_select_input ? DEFS_CAPACITIVE : DEFS_RESISTIVE;
			else
				eff_mode[s] = stage_cfg[s].mode;
			u_pct[s]    = 23'(u_base) * 23'(stage_cfg[s].start_volt_pct);
			u_thr[s]    = 16'(u_pct[s] / 23'(`DEFS_PCT_FULL));
			u_thr_sq[s] = 32'(u_thr[s]) * 32'(u_thr[s]);
			crit_w[s]   = defs_criteria(phasor_q[s], phasor_q[2], eff_mode[s], stage_cfg[s], u_thr_sq[s]);
			rate_w[s]   = defs_rate(phasor_q[s], stage_cfg[s].start_level);
		end
	end

	// ************************************************
	// Delay step prescaler
	// ************************************************
	logic [18:0] step_cnt_q;
	wire         step_tick = step_cnt_q == 19'(STEP_CYCLES - 1);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			step_cnt_q <= 19'h00000;
		else
			step_cnt_q <= step_tick ? 19'h00000 : step_cnt_q + 19'h00001;
	end

	// ************************************************
	// Stage state and events
	// ************************************************
	logic [1:0]        start_cond_q;
	logic [1:0]        rate_q [2];
	logic [1:0]        start_q;
	logic [1:0]        start_prev_q;
	logic [1:0]        trip_prev_q;
	logic [1:0]        trip_w;
	defs_event_t [1:0] ev_q;

	// Criteria held for one fundamental cycle between evaluations
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			start_cond_q <= 2'h0;
			rate_q       <= '{2'h0, 2'h0};
			start_q      <= 2'h0;
			start_prev_q <= 2'h0;
			trip_prev_q  <= 2'h0;
			ev_q         <= '0;
		end else begin
			if (eval_q) begin
				start_cond_q <= crit_w;
				rate_q       <= rate_w;
			end
			start_q      <= start_cond_q & ~block_in;
			start_prev_q <= start_q;
			trip_prev_q  <= trip_w;
			for (int s = 0; s < 2; s++)
				ev_q[s] <= event_enable[s] ? '{start_on:  start_q[s] && !start_prev_q[s],
				                               start_off: !start_q[s] && start_prev_q[s],
				                               trip_on:   trip_w[s] && !trip_prev_q[s],
				                               trip_off:  !trip_w[s] && trip_prev_q[s]} : '0;
		end
	end

	// Two independent delay timers
	for (genvar s = 0; s < 2; s++) begin : g_stage
		defs_timer u_timer (
			.core_clk   (core_clk),
			.rst_n      (rst_n),
			.step_tick  (step_tick),
			.start_cond (start_cond_q[s]),
			.block_in   (block_in[s]),
			.dependent  (stage_cfg[s].dependent),
			.rate       (rate_q[s]),
			.op_delay   (stage_cfg[s].op_delay),
			.int_time   (stage_cfg[s].int_time),
			.trip_out   (trip_w[s])
		);
	end

	assign start_out   = start_q;
	assign trip_out    = trip_w;
	assign stage_event = ev_q;

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_start_follows: assert property ((start_cond_q[0] && !block_in[0]) |=> start_out[0])
		else $error("start missing with criteria met");
	chk_block_start: assert property (block_in[1] |=> !start_out[1] && !trip_out[1])
		else $error("blocked stage still active");
	chk_mode_switch: assert property ((stage_cfg[0].mode == DEFS_SWITCHED_RESISTIVE_CAPACITIVE_MODE)
		|-> eff_mode[0] == (mode_select_input ? DEFS_CAPACITIVE : DEFS_RESISTIVE))
		else $error("switched mode picked wrong sensing");
	chk_event_gate: assert property (!$past(event_enable[0]) |-> stage_event[0] == 4'h0)
		else $error("event without enable");
	chk_trip_event: assert property (($rose(trip_out[0]) && event_enable[0]) |=> stage_event[0].trip_on)
		else $error("trip event missing");
	chk_eval_cycle: assert property ((sample_valid && last_smp) |=> eval_q ##1 !eval_q)
		else $error("evaluation not once per cycle");
	chk_sum_source: assert property ((stage_cfg[1].source == DEFS_SRC_SUMMED)
		|-> chan_x[1] == summed_phase_residual)
		else $error("summed source not routed");

	cov_start: cover property ($rose(start_out[0]));
	cov_trip: cover property (start_out[1] ##1 $rose(trip_out[1]));
	cov_short_fault: cover property ($rose(start_out[0]) ##[1:1000] $fell(start_out[0]) && !trip_out[0]);
endmodule : defs_stage
`default_nettype wire

// ---- design/defs_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "defs_defines.svh"
module defs_timer (
	input  wire logic        core_clk,   // Stage clock
	input  wire logic        rst_n,      // Async reset, active low
	input  wire logic        step_tick,  // One pulse per delay step
	input  wire logic        start_cond, // Start criteria met
	input  wire logic        block_in,   // Stage blocked
	input  wire logic        dependent,  // Dependent delay selected
	input  wire logic [1:0]  rate,       // Overcurrent ratio class
	input  wire logic [13:0] op_delay,   // Operate delay in steps
	input  wire logic [13:0] int_time,   // Retention time in steps
	output logic             trip_out    // Trip, registered
);
	import defs_pkg::*;

	logic [15:0] acc_q;
	logic [13:0] hold_q;
	logic        trip_q;

	// ************************************************
	// Delay accumulation
	// ************************************************
	// Setting clamped to the longest delay
	wire  [13:0] delay_lim = (op_delay > `DEFS_DELAY_MAX_STEPS) ? `DEFS_DELAY_MAX_STEPS : op_delay;
	// Dependent mode advances faster on heavy faults
	wire  [15:0] acc_inc   = dependent ? (16'h0001 << rate) : 16'h0001;
	wire         over      = acc_q > 16'(delay_lim);

	// Block freezes the count; a dropped start keeps it for the retention time
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q  <= 16'h0000;
			hold_q <= 14'h0000;
			trip_q <= 1'b0;
		end else if (block_in) begin
			trip_q <= 1'b0;
		end else begin
			trip_q <= start_cond && over;
			if (start_cond) begin
				hold_q <= 14'h0000;
				if (step_tick && !over)
					acc_q <= acc_q + acc_inc;
			end else if (acc_q != 16'h0000) begin
				if (hold_q >= int_time) begin
					acc_q  <= 16'h0000;
					hold_q <= 14'h0000;
				end else if (step_tick) begin
					hold_q <= hold_q + 14'h0001;
				end
			end
		end
	end

	assign trip_out = trip_q;

	// ************************************************
	// Checks
	// ************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	chk_trip_after_delay: assert property ((start_cond && !block_in && over) |=> trip_out)
		else $error("trip missing after delay");
	chk_no_early_trip: assert property (trip_out |-> $past(start_cond && !block_in && over))
		else $error("trip without elapsed delay");
	chk_retain_count: assert property ((!start_cond && !block_in && acc_q != 16'h0000 && hold_q < int_time)
		|=> acc_q == $past(acc_q))
		else $error("count lost during retention");
	chk_block_halt: assert property (block_in |=> (acc_q == $past(acc_q) && !trip_out))
		else $error("block did not halt timing");
	cov_retained_trip: cover property ((!start_cond && acc_q != 16'h0000) ##1 start_cond ##[1:1000] trip_out);
endmodule : defs_timer
`default_nettype wire

// ---- sim/defs_meas_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// *****
// Measurement channels: one sample set per clock, 16 per cycle
// *****
module defs_meas_model (
	input  wire logic          core_clk, // Clock
	input  wire logic          rst_n,    // Reset, active low
	input  wire logic [15:0]   i1_amp,   // Residual one amplitude
	input  wire logic [15:0]   i2_amp,   // Residual two amplitude
	input  wire logic [15:0]   ph_amp,   // Amplitude of each phase
	input  wire logic [15:0]   u_amp,    // Voltage amplitude
	input  wire logic [3:0]    i_lead,   // Current lead, sixteenths
	output logic               smp_vld,  // Sample strobe
	output logic signed [17:0] i1,       // Residual one sample
	output logic signed [17:0] i2,       // Residual two sample
	output logic signed [17:0] iph,      // Phase current sample
	output logic signed [17:0] u0        // Voltage sample
);
	localparam logic [14:0] SINQ [0:4] = '{15'h0000, 15'h187E, 15'h2D41, 15'h3B21, 15'h4000};
	logic [3:0] k_q;
	// Quarter table folded; exact at the four axes so phases stay clean
	function automatic logic signed [17:0] wav(input logic [15:0] a, input logic [3:0] k);
		logic [2:0]  m;
		logic [30:0] p;
		m = (k[2:0] > 3'h4) ? 3'h0 - k[2:0] : k[2:0];
		p = 31'(a) * 31'(SINQ[m]);
		wav = k[3] ? -18'(p >> 14) : 18'(p >> 14);
	endfunction : wav
	// Index advances only on taken samples, matching the stage's count from reset
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			k_q <= 4'h0;
			smp_vld <= 1'b0;
		end else begin
			smp_vld <= 1'b1;
			k_q <= k_q + 4'(smp_vld);
		end
	end
	assign i1 = wav(i1_amp, k_q + i_lead);
	assign i2 = wav(i2_amp, k_q + i_lead);
	assign iph = wav(ph_amp, k_q + i_lead);
	assign u0 = wav(u_amp, k_q);
endmodule : defs_meas_model
`default_nettype wire

// ---- sim/defs_stage_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module defs_stage_tb;
	import defs_pkg::*;
	logic                     core_clk, rst_n, smp_vld, msel, chk_req, dvm;
	defs_event_t [1:0]        ev;
	int                       trip_ons;
	logic [15:0]              i1_amp, i2_amp, ph_amp, u_amp, lfsr;
	logic [3:0]               i_lead, ex;
	logic signed [17:0]       i1, i2, iph, u0;
	defs_cfg_t [1:0]          cfg;
	logic [1:0]               blk, start_out, trip_out;
	logic [3:0]               exp_q[$];
	int                       fail_count, total_checks, cyc;
	// *****
	// Stimulus helpers
	// *****
	function automatic logic [15:0] nxt(input logic [15:0] s);
		nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt
	function automatic defs_cfg_t mk(input defs_mode_t md, input defs_src_t sr, input logic [13:0] dl);
		mk = '{mode: md, source: sr, dependent: 1'b0, start_level: 16'h03E8, start_volt_pct: 7'h0A,
			base_cos: 16'sh4000, base_sin: 16'sh0000, half_cos: 16'h376D, op_delay: dl, int_time: 14'h0000};
	endfunction : mk
	// Settle seven full windows before noting the expected start and trip
	task run(input logic [15:0] a1, a2, p, input logic [3:0] ld, input defs_cfg_t c0, c1,
		input logic [1:0] b, input logic ms, input logic [3:0] e);
		i1_amp <= a1;
		i2_amp <= a2;
		ph_amp <= p;
		i_lead <= ld;
		cfg <= {c1, c0};
		blk <= b;
		msel <= ms;
		repeat (120) @(posedge core_clk);
		exp_q.push_back(e);
		chk_req <= 1'b1;
		@(posedge core_clk);
		chk_req <= 1'b0;
	endtask : run
	task end_sim;
		total_checks++;
		if (trip_ons !== 1) begin
			fail_count++;
			$display("BAD trip_on_events expected 1 seen %0d", trip_ons);
		end
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	defs_meas_model i_meas (.core_clk(core_clk), .rst_n(rst_n), .i1_amp(i1_amp), .i2_amp(i2_amp),
		.ph_amp(ph_amp), .u_amp(u_amp), .i_lead(i_lead), .smp_vld(smp_vld), .i1(i1), .i2(i2), .iph(iph), .u0(u0));
	defs_stage #(.STEP_CYCLES(4)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .sample_valid(smp_vld),
		.residual_input_one(i1), .residual_input_two(i2), .phase_a_current(iph), .phase_b_current(iph),
		.phase_c_current(iph), .neutral_displacement_voltage(u0), .line_a_voltage(u0), .line_b_voltage(u0),
		.line_c_voltage(u0), .mode_select_input(msel), .derived_voltage_mode(dvm), .vt_nominal(16'h0FA0),
		.neutral_voltage_transformer_sec(16'h03E8), .stage_cfg(cfg), .block_in(blk), .event_enable(2'b11),
		.start_out(start_out), .trip_out(trip_out), .stage_event(ev));
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// Watcher: oldest note against {start, trip}
	always @(posedge core_clk) begin
		cyc++;
		if (ev[0].trip_on === 1'b1)
			trip_ons++;
		if (chk_req) begin
			ex = exp_q.pop_front();
			total_checks++;
			if ({start_out, trip_out} !== ex) begin
				fail_count++;
				$display("BAD start_trip expected %b seen %b", ex, {start_out, trip_out});
			end
		end
		if (cyc == 4000) begin
			fail_count++;
			end_sim();
		end
	end
	// Main sequence; voltage absent first, so undirected start must not need it
	initial begin
		{rst_n, msel, chk_req, blk, i_lead, dvm} = '0;
		trip_ons = 0;
		{i1_amp, i2_amp, ph_amp, u_amp} = '0;
		cfg = '0;
		lfsr = nxt(16'h000E);
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		run(16'h07D0 + (lfsr & 16'h07FF), 0, 0, 0, mk(DEFS_NONDIRECTIONAL, DEFS_SRC_RESIDUAL_ONE, 200),
			mk(DEFS_NONDIRECTIONAL, DEFS_SRC_RESIDUAL_TWO, 200), 0, 0, 4'b0100);
		u_amp <= 16'h0FA0;
		lfsr = nxt(lfsr);
		run(16'h0BB8, 16'h07D0 + (lfsr & 16'h07FF), 0, 0, mk(DEFS_NONDIRECTIONAL, DEFS_SRC_RESIDUAL_ONE, 10),
			mk(DEFS_NONDIRECTIONAL, DEFS_SRC_RESIDUAL_TWO, 200), 0, 0, 4'b1101);
		run(16'h0BB8, 16'h0BB8, 0, 0, mk(DEFS_NONDIRECTIONAL, DEFS_SRC_RESIDUAL_ONE, 10),
			mk(DEFS_NONDIRECTIONAL, DEFS_SRC_RESIDUAL_TWO, 200), 2'b01, 0, 4'b1000);
		run(0, 0, 16'h0258, 0, mk(DEFS_NONDIRECTIONAL, DEFS_SRC_SUMMED, 200),
			mk(DEFS_NONDIRECTIONAL, DEFS_SRC_RESIDUAL_ONE, 200), 0, 0, 4'b0100);
		run(16'h0BB8, 0, 0, 0, mk(DEFS_RESISTIVE, DEFS_SRC_RESIDUAL_ONE, 200),
			mk(DEFS_SECTOR, DEFS_SRC_RESIDUAL_ONE, 200), 0, 0, 4'b1100);
		run(16'h0BB8, 0, 0, 4, mk(DEFS_RESISTIVE, DEFS_SRC_RESIDUAL_ONE, 200),
			mk(DEFS_CAPACITIVE, DEFS_SRC_RESIDUAL_ONE, 200), 0, 0, 4'b1000);
		run(16'h0BB8, 0, 0, 4, mk(DEFS_SECTOR, DEFS_SRC_RESIDUAL_ONE, 200),
			mk(DEFS_SWITCHED_RESISTIVE_CAPACITIVE_MODE, DEFS_SRC_RESIDUAL_ONE, 200), 0, 1, 4'b1000);
		run(16'h0BB8, 0, 0, 4, mk(DEFS_SWITCHED_RESISTIVE_CAPACITIVE_MODE, DEFS_SRC_RESIDUAL_ONE, 200),
			mk(DEFS_SWITCHED_RESISTIVE_CAPACITIVE_MODE, DEFS_SRC_RESIDUAL_ONE, 200), 0, 0, 4'b0000);
		run(16'h0BB8, 0, 0, 0, mk(DEFS_SWITCHED_RESISTIVE_CAPACITIVE_MODE, DEFS_SRC_RESIDUAL_ONE, 200),
			mk(DEFS_SWITCHED_RESISTIVE_CAPACITIVE_MODE, DEFS_SRC_RESIDUAL_ONE, 200), 0, 0, 4'b1100);
		run(16'h01F4, 0, 0, 0, mk(DEFS_NONDIRECTIONAL, DEFS_SRC_RESIDUAL_ONE, 200),
			mk(DEFS_NONDIRECTIONAL, DEFS_SRC_RESIDUAL_ONE, 200), 0, 0, 4'b0000);
		dvm <= 1'b1;
		run(16'h0BB8, 0, 0, 0, mk(DEFS_RESISTIVE, DEFS_SRC_RESIDUAL_ONE, 200),
			mk(DEFS_SECTOR, DEFS_SRC_RESIDUAL_ONE, 200), 0, 0, 4'b1100);
		repeat (2) @(posedge core_clk);
		end_sim();
	end
endmodule : defs_stage_tb
`default_nettype wire
